// *** logic/branch_modifier.sv ***
// next-address modifier for one microbranch test field
`timescale 1ns/10ps
module branch_modifier #(
    parameter int ADDR_W = 8,
    parameter int SEL_W = 5
) (
    input wire logic [SEL_W-1:0] testSel,
    input wire logic [(1<<SEL_W)-1:0] conds,
    input wire logic [ADDR_W-1:0] orMask,
    input wire logic [ADDR_W-1:0] baseAddr,
    output logic [ADDR_W-1:0] modAddr,
    output logic taken
);
    // test code zero means no test; a met condition forces mask bits to one
    assign taken = (testSel != '0) && conds[testSel];
    assign modAddr = taken ? (baseAddr | orMask) : baseAddr;
endmodule

// *** logic/microword_field_decoder.sv ***
// decoder for microword bits 24..0 with bank select and avalon registers
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module microword_field_decoder #(
    parameter int NXT_BITS = 8,
    parameter int BR_SEL_W = 5,
    parameter int OPT_SEL_W = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ufield_pkg::WORD_W-1:0] baseWord,
    input wire logic [ufield_pkg::WORD_W-1:0] optWord,
    input wire logic [OPT_SEL_W-1:0] optBranchField,
    input wire logic [(1<<BR_SEL_W)-1:0] branchConds,
    input wire logic [(1<<OPT_SEL_W)-1:0] optBranchConds,
    input wire logic [NXT_BITS-1:0] branchOrMask,
    input wire logic [ufield_pkg::IR_W-1:0] instructionReg,
    input wire logic [ufield_pkg::GREG_W-1:0] busAddrLow,
    input wire logic uStep,
    input wire logic optEnter,
    input wire logic optExit,
    input wire logic [ufield_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [ufield_pkg::UADDR_W-1:0] nextUAddr,
    output logic baseRomEnable,
    output logic optRomEnable,
    output logic [ufield_pkg::GREG_W-1:0] regAddr,
    output logic regAddrValid,
    output logic busAddrMuxSel,
    output logic [ufield_pkg::DMX_W-1:0] dataMuxSel,
    output logic branchTaken
);
    import ufield_pkg::*;

    // ------------------------------------------------------------
    // bank select flip-flop and control register
    // ------------------------------------------------------------
    logic romBankSelect_r;
    logic hold_r;
    logic ackPend_r;
    logic busReq;
    logic wrTake;
    logic [31:0] readdata_r;

    assign busReq = avs_read | avs_write;
    assign wrTake = avs_write & ackPend_r;

    // hardware entry sets the bit; a clearing event in the same cycle loses
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            romBankSelect_r <= CTRL_RST[CTRL_BANK_BIT];
        end else if (optEnter) begin
            romBankSelect_r <= 1'b1;
        end else if (wrTake && avs_address == CTRL_OFS) begin
            romBankSelect_r <= avs_writedata[CTRL_BANK_BIT];
        end else if (optExit) begin
            romBankSelect_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hold_r <= CTRL_RST[CTRL_HOLD_BIT];
        end else if (wrTake && avs_address == CTRL_OFS) begin
            hold_r <= avs_writedata[CTRL_HOLD_BIT];
        end
    end

    assign baseRomEnable = ~romBankSelect_r;
    assign optRomEnable = romBankSelect_r;

    // ------------------------------------------------------------
    // active word: disabled base store reads as all low
    // ------------------------------------------------------------
    logic [WORD_W-1:0] activeWord;
    assign activeWord = (romBankSelect_r ? '0 : baseWord)
        | (romBankSelect_r ? optWord : '0);

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [NXT_BITS-1:0] nextAddrField;
    logic [GREG_W-1:0] immRegField;
    logic selImmReg;
    logic selBusaddrReg;
    logic selDestReg;
    logic selSrcReg;
    logic [BR_SEL_W-1:0] branchTestField;
    logic busaddrMuxSel;
    logic [DMX_W-1:0] dataMuxField;

    assign nextAddrField = activeWord[NXT_LSB +: NXT_BITS];
    assign immRegField = activeWord[IMM_LSB +: IMM_W];
    assign selImmReg = activeWord[SEL_IMM_BIT];
    assign selBusaddrReg = activeWord[SEL_BA_BIT];
    assign selDestReg = activeWord[SEL_DST_BIT];
    assign selSrcReg = activeWord[SEL_SRC_BIT];
    assign branchTestField = activeWord[BRT_LSB +: BR_SEL_W];
    assign busaddrMuxSel = activeWord[BAM_BIT];
    assign dataMuxField = activeWord[DMX_LSB +: DMX_W];

    // ------------------------------------------------------------
    // branch modification of the next address
    // ------------------------------------------------------------
    logic [NXT_BITS-1:0] baseModAddr;
    logic [NXT_BITS-1:0] optModAddr;
    logic baseTaken;
    logic optTaken;
    logic [NXT_BITS-1:0] modAddr;
    logic takenNow;

    branch_modifier #(
        .ADDR_W(NXT_BITS),
        .SEL_W(BR_SEL_W)
    ) baseBranch (
        .testSel(branchTestField),
        .conds(branchConds),
        .orMask(branchOrMask),
        .baseAddr(nextAddrField),
        .modAddr(baseModAddr),
        .taken(baseTaken)
    );

    branch_modifier #(
        .ADDR_W(NXT_BITS),
        .SEL_W(OPT_SEL_W)
    ) optBranch (
        .testSel(optBranchField),
        .conds(optBranchConds),
        .orMask(branchOrMask),
        .baseAddr(nextAddrField),
        .modAddr(optModAddr),
        .taken(optTaken)
    );

    // option mode ignores the base branch field entirely
    assign modAddr = romBankSelect_r ? optModAddr : baseModAddr;
    assign takenNow = romBankSelect_r ? optTaken : baseTaken;

    // ------------------------------------------------------------
    // general register address select, immediate first
    // ------------------------------------------------------------
    logic [GREG_W-1:0] regAddrNxt;
    logic regValidNxt;

    always_comb begin
        regAddrNxt = '0;
        regValidNxt = 1'b1;
        if (selImmReg) begin
            regAddrNxt = immRegField;
        end else if (selBusaddrReg) begin
            regAddrNxt = busAddrLow;
        end else if (selDestReg) begin
            regAddrNxt = {1'b0, instructionReg[IR_DST_LSB +: IR_FLD_W]};
        end else if (selSrcReg) begin
            regAddrNxt = {1'b0, instructionReg[IR_SRC_LSB +: IR_FLD_W]};
        end else begin
            regValidNxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // latched decode outputs, advanced once per microstep while the hold bit is clear
    // ------------------------------------------------------------
    logic stepGo;
    logic [UADDR_W-1:0] nextUAddr_r;
    logic [GREG_W-1:0] regAddr_r;
    logic regAddrValid_r;
    logic busAddrMuxSel_r;
    logic [DMX_W-1:0] dataMuxSel_r;
    logic branchTaken_r;

    assign stepGo = uStep & ~hold_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            nextUAddr_r <= UADDR_RST;
            branchTaken_r <= 1'b0;
        end else if (stepGo) begin
            nextUAddr_r <= {romBankSelect_r, modAddr};
            branchTaken_r <= takenNow;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            regAddr_r <= '0;
            regAddrValid_r <= 1'b0;
        end else if (stepGo) begin
            regAddr_r <= regAddrNxt;
            regAddrValid_r <= regValidNxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            busAddrMuxSel_r <= 1'b0;
            dataMuxSel_r <= DMX_D_STRAIGHT;
        end else if (stepGo) begin
            busAddrMuxSel_r <= busaddrMuxSel;
            dataMuxSel_r <= dataMuxField;
        end
    end

    assign nextUAddr = nextUAddr_r;
    assign regAddr = regAddr_r;
    assign regAddrValid = regAddrValid_r;
    assign busAddrMuxSel = busAddrMuxSel_r;
    assign dataMuxSel = dataMuxSel_r;
    assign branchTaken = branchTaken_r;

    // ------------------------------------------------------------
    // avalon slave: one wait state on every access
    // ------------------------------------------------------------
    logic [31:0] readMux;

    always_comb begin
        readMux = 32'h0000_0000;
        unique case (avs_address)
            CTRL_OFS: begin
                readMux[CTRL_BANK_BIT] = romBankSelect_r;
                readMux[CTRL_HOLD_BIT] = hold_r;
            end
            STAT_OFS: begin
                readMux[STAT_UADDR_LSB +: UADDR_W] = nextUAddr_r;
                readMux[STAT_GREG_LSB +: GREG_W] = regAddr_r;
                readMux[STAT_GVALID_BIT] = regAddrValid_r;
                readMux[STAT_TAKEN_BIT] = branchTaken_r;
                readMux[STAT_BAM_BIT] = busAddrMuxSel_r;
                readMux[STAT_DMX_LSB +: DMX_W] = dataMuxSel_r;
            end
            WORD_OFS: begin
                readMux[WORD_W-1:0] = activeWord;
            end
            default: begin
                readMux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ackPend_r <= 1'b0;
        end else begin
            ackPend_r <= busReq & ~ackPend_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && !ackPend_r) begin
            readdata_r <= readMux;
        end
    end

    assign avs_waitrequest = busReq & ~ackPend_r;
    assign avs_readdata = readdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence stepWithImm;
        stepGo && selImmReg;
    endsequence

    sequence stepWithDest;
        stepGo && !selImmReg && !selBusaddrReg && selDestReg;
    endsequence

    next_addr_plain_a: assert property (
        stepGo && !takenNow |=> nextUAddr[NXT_BITS-1:0] == $past(nextAddrField))
        else $error("next address differs from field without a branch");

    branch_or_a: assert property (
        stepGo && takenNow |=>
            nextUAddr[NXT_BITS-1:0] == ($past(nextAddrField) | $past(branchOrMask)))
        else $error("taken branch did not or the mask into the address");

    bank_bit_a: assert property (
        stepGo |=> nextUAddr[UADDR_W-1] == $past(romBankSelect_r))
        else $error("address bit 8 does not follow the bank flip-flop");

    rom_enable_a: assert property (
        baseRomEnable != optRomEnable && optRomEnable == romBankSelect_r)
        else $error("rom enables not exclusive");

    opt_base_low_a: assert property (
        romBankSelect_r |-> activeWord == optWord)
        else $error("base bits leak while option drives");

    bank_set_wins_a: assert property (
        optEnter && optExit |=> romBankSelect_r)
        else $error("option entry lost against exit");

    imm_select_a: assert property (
        stepWithImm |=> regAddr == $past(immRegField) && regAddrValid)
        else $error("immediate register address not used");

    dest_select_a: assert property (
        stepWithDest |=> regAddr == {1'b0, $past(instructionReg[2:0])})
        else $error("destination register address wrong");

    low_half_a: assert property (
        stepGo && !selImmReg && !selBusaddrReg && (selDestReg || selSrcReg)
            |=> !regAddr[GREG_W-1])
        else $error("instruction field reached upper registers");

    opt_branch_a: assert property (
        romBankSelect_r && optBranchField == '0 |-> !takenNow)
        else $error("base branch field tested in option mode");

    data_mux_a: assert property (
        stepGo ##1 !stepGo |-> dataMuxSel == $past(dataMuxField, 1))
        else $error("data mux select not latched from word");

    bus_wait_a: assert property (
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("read held off longer than one cycle");
endmodule

// *** logic/ufield_pkg.sv ***
// constants for the low-order microword field decoder
package ufield_pkg;
    // ------------------------------------------------------------
    // microword field positions
    // ------------------------------------------------------------
    localparam int WORD_W = 25;
    localparam int NXT_LSB = 0;
    localparam int NXT_W = 8;
    localparam int IMM_LSB = 9;
    localparam int IMM_W = 4;
    localparam int SEL_IMM_BIT = 13;
    localparam int SEL_BA_BIT = 14;
    localparam int SEL_DST_BIT = 15;
    localparam int SEL_SRC_BIT = 16;
    localparam int BRT_LSB = 17;
    localparam int BRT_W = 5;
    localparam int OPT_BRT_W = 4;
    localparam int BAM_BIT = 22;
    localparam int DMX_LSB = 23;
    localparam int DMX_W = 2;
    localparam int UADDR_W = 9;
    localparam int GREG_W = 4;
    localparam int IR_DST_LSB = 0;
    localparam int IR_SRC_LSB = 6;
    localparam int IR_FLD_W = 3;
    localparam int IR_W = 16;

    // ------------------------------------------------------------
    // data mux source encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DMX_D_STRAIGHT = 2'h0,
        DMX_READ_BUS = 2'h1,
        DMX_D_SHIFT_R = 2'h2,
        DMX_SYS_BUS = 2'h3
    } data_mux_t;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int AV_ADDR_W = 4;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] WORD_OFS = 4'h8;
    localparam int CTRL_BANK_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_UADDR_LSB = 0;
    localparam int STAT_GREG_LSB = 12;
    localparam int STAT_GVALID_BIT = 16;
    localparam int STAT_TAKEN_BIT = 17;
    localparam int STAT_BAM_BIT = 18;
    localparam int STAT_DMX_LSB = 20;
    localparam logic [8:0] UADDR_RST = 9'h000;
endpackage

// *** sim/microword_field_decoder_tb.sv ***
// self-checking bench for the microword field decoder
`timescale 1ns/10ps
module microword_field_decoder_tb;
    import ufield_pkg::*;
    logic sys_clk, reset_n, uStep, optEnter, optExit, avs_read, avs_write;
    logic [WORD_W-1:0] baseWord, optWord;
    logic [3:0] optBranchField, busAddrLow, avs_address;
    logic [31:0] branchConds, avs_writedata, avs_readdata;
    logic [15:0] optBranchConds, instrVal;
    logic [7:0] branchOrMask;
    logic [8:0] nextUAddr, curAddr;
    logic baseRomEnable, optRomEnable, regAddrValid, busAddrMuxSel, branchTaken, bankExp;
    logic [3:0] regAddr;
    logic [1:0] dataMuxSel;
    logic avs_waitrequest;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [3:0] selTab [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
    logic [3:0] regTab [6] = '{4'hA, 4'h9, 4'h5, 4'h7, 4'hA, 4'h0};

    microword_field_decoder i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .baseWord(baseWord),
        .optWord(optWord), .optBranchField(optBranchField), .branchConds(branchConds),
        .optBranchConds(optBranchConds), .branchOrMask(branchOrMask),
        .instructionReg(instrVal), .busAddrLow(busAddrLow), .uStep(uStep),
        .optEnter(optEnter), .optExit(optExit), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .nextUAddr(nextUAddr), .baseRomEnable(baseRomEnable), .optRomEnable(optRomEnable),
        .regAddr(regAddr), .regAddrValid(regAddrValid), .busAddrMuxSel(busAddrMuxSel),
        .dataMuxSel(dataMuxSel), .branchTaken(branchTaken));
    ustore_model store (.fetchAddr(nextUAddr), .baseRomEnable(baseRomEnable),
        .optRomEnable(optRomEnable), .baseWord(baseWord), .optWord(optWord));

    // ----
    // tasks
    // ----
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask
    task automatic av_read(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        av_xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic av_write(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] rd;
        av_xfer(1'b1, a, d, rd);
    endtask
    function automatic logic [24:0] mkw(input logic [1:0] dm, input logic bm,
        input logic [4:0] bt, input logic [3:0] sl, input logic [3:0] im, input logic b8,
        input logic [7:0] nx);
        return {dm, bm, bt, sl, im, b8, nx};
    endfunction
    task automatic pulse_step();
        @(posedge sys_clk);
        uStep <= 1'b1;
        @(posedge sys_clk);
        uStep <= 1'b0;
        #1;
    endtask
    task automatic step(input logic [24:0] w, input logic tk, input logic [3:0] eReg,
                        input logic eVal);
        logic [8:0] eAddr;
        store.load(bankExp, curAddr[7:0], w);
        eAddr = {bankExp, w[7:0] | (tk ? branchOrMask : 8'h00)};
        pulse_step();
        chk(nextUAddr, eAddr);
        chk(branchTaken, tk);
        chk({regAddrValid, regAddr}, {eVal, eReg});
        chk({busAddrMuxSel, dataMuxSel}, {w[22], w[24:23]});
        curAddr = eAddr;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----
    // scenarios
    // ----
    initial begin
        reset_n = 1'b0;
        {uStep, optEnter, optExit, avs_read, avs_write} = '0;
        {optBranchField, avs_address, avs_writedata, optBranchConds} = '0;
        branchConds = 32'h0;
        branchOrMask = 8'h05;
        instrVal = 16'h03CD;
        busAddrLow = 4'h9;
        curAddr = 9'h000;
        bankExp = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({optRomEnable, baseRomEnable, nextUAddr}, 11'h200);
        av_read(CTRL_OFS, 32'h0);
        av_read(4'hC, 32'h0);
        for (int i = 0; i < 6; i++) begin
            step(mkw(i[1:0], i[0], 5'h00, selTab[i], 4'hA, 1'b1, 8'(8'h10 + i)), 1'b0,
                 regTab[i], i != 5);
        end
        @(posedge sys_clk);
        branchConds <= 32'h0000_0008;
        step(mkw(2'h0, 1'b0, 5'h03, 4'h0, 4'h0, 1'b0, 8'hF0), 1'b1, 4'h0, 1'b0);
        av_read(STAT_OFS, 32'h0002_00F5);
        step(mkw(2'h0, 1'b0, 5'h04, 4'h0, 4'h0, 1'b0, 8'hF0), 1'b0, 4'h0, 1'b0);
        @(posedge sys_clk);
        branchConds <= 32'hFFFF_FFFF;
        step(mkw(2'h1, 1'b0, 5'h00, 4'h0, 4'h0, 1'b0, 8'h33), 1'b0, 4'h0, 1'b0);
        av_write(CTRL_OFS, 32'h2);
        av_read(CTRL_OFS, 32'h2);
        store.load(1'b0, curAddr[7:0], mkw(2'h0, 1'b0, 5'h00, 4'h0, 4'h0, 1'b0, 8'h77));
        pulse_step();
        chk(nextUAddr, curAddr);
        av_write(CTRL_OFS, 32'h0);
        @(posedge sys_clk);
        optEnter <= 1'b1;
        optBranchField <= 4'h2;
        optBranchConds <= 16'h0004;
        @(posedge sys_clk);
        optEnter <= 1'b0;
        #1;
        chk({optRomEnable, baseRomEnable}, 2'h2);
        bankExp = 1'b1;
        store.load(1'b1, 8'h45, mkw(2'h2, 1'b1, 5'h1F, 4'hC, 4'h3, 1'b0, 8'h81));
        step(mkw(2'h3, 1'b1, 5'h1F, 4'h1, 4'h6, 1'b0, 8'h40), 1'b1, 4'h6, 1'b1);
        av_read(WORD_OFS, {7'h0, mkw(2'h2, 1'b1, 5'h1F, 4'hC, 4'h3, 1'b0, 8'h81)});
        @(posedge sys_clk);
        optBranchField <= 4'h0;
        step(mkw(2'h0, 1'b0, 5'h1F, 4'h0, 4'h0, 1'b0, 8'h22), 1'b0, 4'h0, 1'b0);
        @(posedge sys_clk);
        optEnter <= 1'b1;
        optExit <= 1'b1;
        @(posedge sys_clk);
        optEnter <= 1'b0;
        #1;
        chk({optRomEnable, baseRomEnable}, 2'h2);
        @(posedge sys_clk);
        optExit <= 1'b0;
        #1;
        chk({optRomEnable, baseRomEnable}, 2'h1);
        bankExp = 1'b0;
        av_write(CTRL_OFS, 32'h1);
        chk({optRomEnable, baseRomEnable}, 2'h2);
        av_write(CTRL_OFS, 32'h0);
        chk({optRomEnable, baseRomEnable}, 2'h1);
        step(mkw(2'h2, 1'b0, 5'h00, 4'h2, 4'h0, 1'b0, 8'h7E), 1'b0, 4'h9, 1'b1);
        tally_and_finish();
    end
endmodule

// *** sim/ustore_model.sv ***
// control store model: base and option words fetched at the sequencer address
`timescale 1ns/10ps
module ustore_model (
    input wire logic [ufield_pkg::UADDR_W-1:0] fetchAddr,
    input wire logic baseRomEnable,
    input wire logic optRomEnable,
    output logic [ufield_pkg::WORD_W-1:0] baseWord,
    output logic [ufield_pkg::WORD_W-1:0] optWord
);
    import ufield_pkg::*;
    logic [WORD_W-1:0] baseMem [256];
    logic [WORD_W-1:0] optMem [256];
    // a disabled store drives every output low
    assign baseWord = baseRomEnable ? baseMem[fetchAddr[7:0]] : '0;
    assign optWord = optRomEnable ? optMem[fetchAddr[7:0]] : '0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            baseMem[i] = '0;
            optMem[i] = '0;
        end
    end
    task automatic load(input logic opt, input logic [7:0] a, input logic [WORD_W-1:0] w);
        if (opt) begin
            optMem[a] = w;
        end else begin
            baseMem[a] = w;
        end
    endtask
endmodule
